// ==== src/iowd_pkg.sv ====
package iowd_pkg;
   // I/O port addresses decoded on host read cycles
   localparam logic [15:0] DISABLE_PORT_ADDR = 16'h0043;
   localparam logic [15:0] ARM_PORT_ADDR     = 16'h0443;
   // Read data has no meaning; a fixed value is returned
   localparam logic [7:0]  READ_DATA_VALUE   = 8'hFF;
   // Timing
   localparam int          CLK_HZ            = 200_000_000;
   localparam int          INTERVAL_MS       = 2000;
   localparam int          INTERVAL_CYCLES   = CLK_HZ / 1000 * INTERVAL_MS;
   localparam int          RESET_PULSE_CYCLES = 16;
   // Expiry action selection
   localparam logic        ACTION_RESET      = 1'b0;
   localparam logic        ACTION_IRQ        = 1'b1;
   typedef enum logic [1:0] {IOWD_DISARMED, IOWD_ARMED, IOWD_FIRED} iowd_state_e;
endpackage

// ==== src/iowd_counter.sv ====
`timescale 1ns/1ps
// Loadable down counter; flags the step to zero for one cycle while running
module iowd_counter #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             load_in,
   input  wire logic             run_in,
   input  wire logic [WIDTH-1:0] value_in,
   output logic                  zero_out
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic             zero_q;

   // Load wins over counting so a refresh is never lost
   assign count_d = load_in ? value_in :
                    (run_in && count_q != '0) ? count_q - WIDTH'(1) : count_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_q <= '0;
         zero_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         zero_q  <= run_in && !load_in && count_q == WIDTH'(1);
      end
   end

   assign zero_out = zero_q;
endmodule

// ==== src/iowd_top.sv ====
`timescale 1ns/1ps
// Contract
// - First arm-port read arms the countdown
// - Arm-port read while armed restarts full interval
// - Expiry resets CPU or raises IRQ11
// - Disable-port read disarms and stops countdown
module iowd_top #(
   parameter int INTERVAL_CYCLES = iowd_pkg::INTERVAL_CYCLES,
   parameter int CNT_WIDTH       = 32
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] io_addr_in,
   input  wire logic        io_rd_in,
   input  wire logic        action_sel_in,
   output logic [7:0]       io_rdata_out,
   output logic             io_hit_out,
   output logic             cpu_reset_out,
   output logic             irq11_out,
   output logic             armed_out
);
   // The watchdog is driven only by host read cycles. A read strobe is taken
   // on the rising edge at which io_rd_in is high; its address picks the arm
   // port or the disable port, and every other address is ignored. Reads of
   // the arm port both arm and refresh, so host software needs one loop only.
   // A read of the disable port stops the countdown at once. The expiry action
   // is a finite CPU reset pulse or a standing IRQ level, picked by a strap.

   // Reset pulse counter width, sized so the pulse length always fits
   localparam int PULSE_W = $clog2(iowd_pkg::RESET_PULSE_CYCLES + 1);

   // Arming state and its next value
   iowd_pkg::iowd_state_e state_q;
   iowd_pkg::iowd_state_e state_d;

   // One register behind every output so no decode reaches a pin
   logic                  armed_q;
   logic                  armed_d;
   logic                  cpu_reset_q;
   logic                  cpu_reset_d;
   logic                  irq_q;
   logic                  irq_d;
   logic                  hit_q;
   logic                  hit_d;
   logic [7:0]            rdata_q;

   // Reset pulse length counter and its next value
   logic [PULSE_W-1:0]    pulse_q;
   logic [PULSE_W-1:0]    pulse_d;

   // One-cycle expiry flag from the interval counter
   logic                  expired;

   // Port decode on each host read strobe; other addresses are left alone
   wire rd_arm    = io_rd_in && io_addr_in == iowd_pkg::ARM_PORT_ADDR;
   wire rd_dis    = io_rd_in && io_addr_in == iowd_pkg::DISABLE_PORT_ADDR;
   wire rd_any    = rd_arm || rd_dis;
   wire armed     = state_q == iowd_pkg::IOWD_ARMED;

   // Counter control; the disable port wins over an arm read in one cycle
   wire cnt_load  = rd_arm && !rd_dis;
   wire cnt_run   = armed && !rd_dis;

   // Expiry acts only while armed and with no port read in that cycle, so a
   // refresh or disable that lands exactly on the deadline still saves the CPU
   wire fire      = armed && expired && !rd_any;
   wire fire_rst  = fire && action_sel_in == iowd_pkg::ACTION_RESET;
   wire fire_irq  = fire && action_sel_in == iowd_pkg::ACTION_IRQ;

   // Pulse counter status
   wire pulse_on  = pulse_q != '0;
   wire pulse_end = pulse_q == PULSE_W'(1);

   // Interval countdown. It is loaded with the full interval on every arm read
   // and counts only while armed. Its zero flag is registered, so the expiry
   // action shows INTERVAL_CYCLES + 1 cycles after the last arm read. With the
   // default interval the count needs 29 bits; CNT_WIDTH leaves headroom, and
   // a narrower CNT_WIDTH would silently shorten the interval.
   iowd_counter #(
      .WIDTH (CNT_WIDTH)
   ) iowd_counter_inst (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .load_in  (cnt_load),
      .run_in   (cnt_run),
      .value_in (CNT_WIDTH'(INTERVAL_CYCLES)),
      .zero_out (expired)
   );

   // Next arming state; a refresh or disable in the expiry cycle beats the expiry
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         iowd_pkg::IOWD_DISARMED: begin
            if (cnt_load) state_d = iowd_pkg::IOWD_ARMED;
         end
         iowd_pkg::IOWD_ARMED: begin
            if (rd_dis) state_d = iowd_pkg::IOWD_DISARMED;
            else if (cnt_load) state_d = iowd_pkg::IOWD_ARMED;
            else if (fire) state_d = iowd_pkg::IOWD_FIRED;
         end
         iowd_pkg::IOWD_FIRED: begin
            // After expiry the watchdog waits, disarmed, until the host arms it
            if (rd_dis) state_d = iowd_pkg::IOWD_DISARMED;
            else if (cnt_load) state_d = iowd_pkg::IOWD_ARMED;
         end
         default: begin
            // The unused code falls back to the safe, disarmed state
            state_d = iowd_pkg::IOWD_DISARMED;
         end
      endcase
   end

   // Next armed flag follows the next state so the output needs no decode
   assign armed_d = state_d == iowd_pkg::IOWD_ARMED;

   // Reset pulse: loaded on expiry in reset mode, then counted down to zero
   assign pulse_d = fire_rst ? PULSE_W'(iowd_pkg::RESET_PULSE_CYCLES) :
                    pulse_on ? pulse_q - PULSE_W'(1) : pulse_q;

   // The CPU reset is a finite pulse; a held reset would keep the CPU from
   // ever coming back to refresh the watchdog
   assign cpu_reset_d = fire_rst || (pulse_on && !pulse_end);

   // The IRQ is a level that stands until the handler reads either port;
   // the set wins over a clear, though expiry already excludes a read
   assign irq_d = fire_irq || (irq_q && !rd_any);

   // Read acknowledge for either watchdog port
   assign hit_d = rd_any;

   // Arming state; a system reset always leaves the watchdog disarmed, also
   // when that reset was the watchdog's own pulse fed back to the board
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= iowd_pkg::IOWD_DISARMED;
      end else begin
         state_q <= state_d;
      end
   end

   // Armed flag register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
      end
   end

   // Reset pulse length counter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pulse_q <= '0;
      end else begin
         pulse_q <= pulse_d;
      end
   end

   // CPU reset output register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cpu_reset_q <= 1'b0;
      end else begin
         cpu_reset_q <= cpu_reset_d;
      end
   end

   // IRQ output register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Read acknowledge register, one cycle after the taken read
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end

   // Read data carries no meaning; it is a fixed value held in a register so
   // the data pins never depend on the address decode
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= iowd_pkg::READ_DATA_VALUE;
      end else begin
         rdata_q <= iowd_pkg::READ_DATA_VALUE;
      end
   end

   // Outputs straight from their registers
   assign io_rdata_out  = rdata_q;
   assign io_hit_out    = hit_q;
   assign cpu_reset_out = cpu_reset_q;
   assign irq11_out     = irq_q;
   assign armed_out     = armed_q;
endmodule

// ==== tb/iowd_assertions.sv ====
`timescale 1ns/1ps
// Port-level watchdog checks
module iowd_assertions #(
   parameter int INTERVAL_CYCLES = iowd_pkg::INTERVAL_CYCLES
) (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [15:0] io_addr_in,
   input wire logic        io_rd_in,
   input wire logic        action_sel_in,
   input wire logic        io_hit_out,
   input wire logic        cpu_reset_out,
   input wire logic        irq11_out,
   input wire logic        armed_out
);
   // Cycles since the last arm read, saturating; the interval is too long to unroll
   logic [31:0] since_q;
   always_ff @(posedge clk_in) begin
      if (rst_in) since_q <= 32'h0;
      else if (io_rd_in && io_addr_in == 16'h0443) since_q <= 32'h0;
      else if (since_q != 32'hFFFFFFFF) since_q <= since_q + 32'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_arm; io_rd_in && io_addr_in == 16'h0443; endsequence
   sequence s_off; io_rd_in && io_addr_in == 16'h0043; endsequence
   property p_arm; s_arm |=> armed_out; endproperty
   // An arm read followed by eight read-free cycles must still leave armed set
   property p_refresh; s_arm ##1 !io_rd_in [*8] |=> armed_out; endproperty
   property p_hit; io_rd_in && (io_addr_in == 16'h0443 || io_addr_in == 16'h0043)
      |=> io_hit_out; endproperty
   // Expiry action appears exactly one interval plus one cycle after the last arm read
   property p_expiry; $rose(cpu_reset_out) || $rose(irq11_out)
      |-> since_q == 32'(INTERVAL_CYCLES + 1); endproperty
   property p_off; s_off |=> !armed_out; endproperty
   // Expiry is the only fall of armed without a read just before it
   property p_fire; $fell(armed_out) && !$past(io_rd_in)
      |-> (action_sel_in ? irq11_out : cpu_reset_out); endproperty
   property p_rst; $fell(rst_in) |-> !armed_out && !irq11_out && !cpu_reset_out; endproperty
   a_arm: assert property (p_arm) else $error("arm read did not arm");
   a_refresh: assert property (p_refresh) else $error("refresh dropped armed");
   a_off: assert property (p_off) else $error("disable read left armed");
   a_fire: assert property (p_fire) else $error("expiry action missing");
   a_rst: assert property (p_rst) else $error("not idle after reset");
   a_hit: assert property (p_hit) else $error("port read not acknowledged");
   a_expiry: assert property (p_expiry) else $error("expiry at wrong time");
endmodule

// ==== tb/iowd_host.sv ====
`timescale 1ns/1ps
// Host CPU issuing single-cycle I/O reads
module iowd_host (
   input  wire logic   clk_in,
   output logic [15:0] io_addr_out,
   output logic        io_rd_out
);
   initial begin
      io_rd_out = 1'b0;
      io_addr_out = 16'h0000;
   end
   // Idle address is inverted so a stale match cannot pass unnoticed
   task automatic rd(input logic [15:0] a);
      @(negedge clk_in);
      io_addr_out = a;
      io_rd_out = 1'b1;
      @(negedge clk_in);
      io_rd_out = 1'b0;
      io_addr_out = ~a;
   endtask
endmodule

// ==== tb/iowd_top_test.sv ====
`timescale 1ns/1ps
module iowd_top_test;
   logic clk_in, rst_in, sel, rd, hit, crst, irq, armed;
   logic [15:0] addr;
   logic [7:0]  rdata;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   iowd_host iowd_host_inst (.clk_in(clk_in), .io_addr_out(addr), .io_rd_out(rd));
   // Short interval keeps the run brief; waits below derive from 20
   iowd_top #(.INTERVAL_CYCLES(20)) iowd_top_inst (.clk_in(clk_in), .rst_in(rst_in),
      .io_addr_in(addr), .io_rd_in(rd), .action_sel_in(sel), .io_rdata_out(rdata),
      .io_hit_out(hit), .cpu_reset_out(crst), .irq11_out(irq), .armed_out(armed));
   task automatic final_report;
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s exp %0h got %0h", n, e, g);
      end
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         final_report;
      end
   end
   initial begin
      rst_in = 1'b1;
      sel = 1'b0;
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      chk("armed", armed, 1'b0);
      chk("quiet", crst | irq | hit, 1'b0);
      chk("rdata", rdata, iowd_pkg::READ_DATA_VALUE);
      iowd_host_inst.rd(16'h0443);
      chk("armed", armed, 1'b1);
      chk("hit", hit, 1'b1);
      repeat (15) @(negedge clk_in);
      iowd_host_inst.rd(16'h0443);
      repeat (15) @(negedge clk_in);
      chk("armed", armed, 1'b1);
      iowd_host_inst.rd(16'h0043);
      chk("armed", armed, 1'b0);
      chk("hit", hit, 1'b1);
      repeat (10) @(negedge clk_in);
      chk("quiet", armed | crst | irq | hit, 1'b0);
      iowd_host_inst.rd(16'h0443);
      repeat (20) @(negedge clk_in);
      chk("cpu_reset", crst, 1'b0);
      @(negedge clk_in);
      chk("cpu_reset", crst, 1'b1);
      chk("armed", armed, 1'b0);
      repeat (15) @(negedge clk_in);
      chk("cpu_reset", crst, 1'b1);
      @(negedge clk_in);
      chk("cpu_reset", crst, 1'b0);
      sel = 1'b1;
      iowd_host_inst.rd(16'h0443);
      repeat (20) @(negedge clk_in);
      chk("irq11", irq, 1'b0);
      @(negedge clk_in);
      chk("irq11", irq, 1'b1);
      chk("cpu_reset", crst, 1'b0);
      iowd_host_inst.rd(16'h0443);
      chk("irq11", irq, 1'b0);
      chk("armed", armed, 1'b1);
      // Reset in mid-count must disarm and keep the countdown from firing
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      chk("armed", armed, 1'b0);
      repeat (25) @(negedge clk_in);
      chk("quiet", armed | crst | irq, 1'b0);
      final_report;
   end
endmodule
bind iowd_top iowd_assertions #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) iowd_assertions_inst (
   .clk_in(clk_in), .rst_in(rst_in),
   .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .action_sel_in(action_sel_in),
   .io_hit_out(io_hit_out),
   .cpu_reset_out(cpu_reset_out), .irq11_out(irq11_out), .armed_out(armed_out));
